// file: shared/accept_filter_pkg.sv
// Purpose: Shared constants for the CAN acceptance filter.
// Assumes: 29-bit identifiers; 16 filters; up to 16 receive buffers.
// Notes: Register offsets are word indices on the plain register port.
package accept_filter_pkg;
    localparam int ID_W      = 29;
    localparam int NUM_FILT  = 16;
    localparam int NUM_MASK  = 3;
    localparam int NUM_BUF   = 16;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    // Register offsets, one 32-bit word each.
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_FEN    = 8'h01;
    localparam logic [7:0] OFF_BASSOC = 8'h02;
    localparam logic [7:0] OFF_MSEL   = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h05;
    localparam logic [7:0] OFF_MASK0  = 8'h08;
    localparam logic [7:0] OFF_MASK1  = 8'h09;
    localparam logic [7:0] OFF_FILT0  = 8'h10;
    localparam logic [7:0] OFF_HIT0   = 8'h20;
    // Control register fields.
    localparam int CTRL_CFG_BIT  = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_ROLL_BIT = 3;
    localparam int CTRL_F15M_BIT = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // Mode 0 filter-hit codes in buffer zero.
    localparam logic [4:0] HIT_B0_F0 = 5'h06;
    localparam logic [4:0] HIT_B0_F1 = 5'h07;
    localparam logic [1:0] MODE_LEGACY = 2'h0;
    // Index of the mask chosen as filter fifteen.
    localparam logic [1:0] MSEL_F15 = 2'h2;
    localparam logic [3:0] MODE0_BUF0 = 4'h0;
    localparam logic [3:0] MODE0_BUF1 = 4'h1;
endpackage : accept_filter_pkg

// file: design/hit_code_mem.sv
// Purpose: Holds one filter-hit code per receive buffer.
// Assumes: One write and one registered read port.
// Notes: Read data are registered, one cycle after the read address.
`timescale 1ns/1ps
`default_nettype none
module hit_code_mem #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [4:0]    wr_data_in,
    input  wire logic [AW-1:0] rd_addr_in,
    output logic      [4:0]    rd_data_out
);
    logic [4:0] mem_ff [DEPTH];
    logic [4:0] nxt_rd;
    always_comb begin
        nxt_rd = mem_ff[rd_addr_in];
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_data_out <= 5'h00;
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= 5'h00;
            end
        end else begin
            rd_data_out <= nxt_rd;
            if (wr_en_in) begin
                mem_ff[wr_addr_in] <= wr_data_in;
            end
        end
    end
endmodule : hit_code_mem
`default_nettype wire

// file: design/filter_match.sv
// Purpose: Compares identifier against filters under masks.
// Assumes: Mask and filter values are stable during a compare.
// Notes: Purely combinational; priority is resolved by the caller.
`timescale 1ns/1ps
`default_nettype none
module filter_match #(
    parameter int ID_W     = 29,
    parameter int NUM_FILT = 16
) (
    input  wire logic [ID_W-1:0]          id_in,
    input  wire logic [NUM_FILT*ID_W-1:0] filt_in,
    input  wire logic [NUM_FILT*ID_W-1:0] mask_in,
    output logic      [NUM_FILT-1:0]      hit_out
);
    // A bit passes when unmasked or equal to the filter bit.
    function automatic logic bit_ok(input logic [ID_W-1:0] f,
                                    input logic [ID_W-1:0] m,
                                    input logic [ID_W-1:0] d);
        bit_ok = &(~m | ~(f ^ d));
    endfunction : bit_ok
    always_comb begin
        for (int i = 0; i < NUM_FILT; i++) begin
            hit_out[i] = bit_ok(filt_in[i*ID_W +: ID_W],
                                mask_in[i*ID_W +: ID_W], id_in);
        end
    end
endmodule : filter_match
`default_nettype wire

// file: design/can_acceptance_filter.sv
// Purpose: Acceptance filtering of assembled CAN messages.
// Assumes: The protocol engine pulses msg_valid_in with a held identifier.
// Notes: Loads are one-cycle pulses with buffer index and hit code.
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module can_acceptance_filter #(
    parameter int ID_W     = accept_filter_pkg::ID_W,
    parameter int NUM_FILT = accept_filter_pkg::NUM_FILT
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    input  wire logic        msg_valid_in,
    input  wire logic [28:0] msg_id_in,
    input  wire logic        buf0_full_in,
    output logic             load_out,
    output logic      [3:0]  load_buf_out,
    output logic      [4:0]  load_hit_out
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0]     ctrl_ff,  nxt_ctrl;
    logic [15:0]     fen_ff,   nxt_fen;
    logic [63:0]     bassoc_ff, nxt_bassoc;
    logic [31:0]     msel_ff,  nxt_msel;
    logic [ID_W-1:0] mask_ff [2];
    logic [ID_W-1:0] nxt_mask [2];
    logic [ID_W-1:0] filt_ff [NUM_FILT];
    logic [ID_W-1:0] nxt_filt [NUM_FILT];
    logic [31:0]     status_ff, nxt_status;
    logic            cfg;
    logic [1:0]      mode;
    logic            roll_en, f15_mask;
    assign cfg      = ctrl_ff[accept_filter_pkg::CTRL_CFG_BIT];
    assign mode     = ctrl_ff[accept_filter_pkg::CTRL_MODE_LSB +: 2];
    assign roll_en  = ctrl_ff[accept_filter_pkg::CTRL_ROLL_BIT];
    assign f15_mask = ctrl_ff[accept_filter_pkg::CTRL_F15M_BIT];
    logic legacy;
    assign legacy = (mode == accept_filter_pkg::MODE_LEGACY);
    // Register writes. Filters and masks lock outside configuration mode
    // so that a compare never sees a half-updated pattern.
    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_fen    = fen_ff;
        nxt_bassoc = bassoc_ff;
        nxt_msel   = msel_ff;
        nxt_mask   = mask_ff;
        nxt_filt   = filt_ff;
        if (reg_wr_in) begin
            case (reg_addr_in)
                accept_filter_pkg::OFF_CTRL:   nxt_ctrl = reg_wdata_in;
                accept_filter_pkg::OFF_FEN:    nxt_fen = reg_wdata_in[15:0];
                accept_filter_pkg::OFF_BASSOC:
                    nxt_bassoc[31:0] = reg_wdata_in;
                accept_filter_pkg::OFF_BASSOC + 8'h01:
                    nxt_bassoc[63:32] = reg_wdata_in;
                accept_filter_pkg::OFF_MSEL:   nxt_msel = reg_wdata_in;
                default: begin
                    if (cfg) begin
                        if (reg_addr_in == accept_filter_pkg::OFF_MASK0) begin
                            nxt_mask[0] = reg_wdata_in[ID_W-1:0];
                        end
                        if (reg_addr_in == accept_filter_pkg::OFF_MASK1) begin
                            nxt_mask[1] = reg_wdata_in[ID_W-1:0];
                        end
                        for (int i = 0; i < NUM_FILT; i++) begin
                            if (reg_addr_in ==
                                accept_filter_pkg::OFF_FILT0 + 8'(i)) begin
                                nxt_filt[i] = reg_wdata_in[ID_W-1:0];
                            end
                        end
                    end
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Per-filter mask choice and enable.
    logic [NUM_FILT*ID_W-1:0] filt_flat, mask_flat;
    logic [NUM_FILT-1:0]      hit, usable;
    always_comb begin
        for (int i = 0; i < NUM_FILT; i++) begin
            filt_flat[i*ID_W +: ID_W] = filt_ff[i];
            if (legacy) begin
                mask_flat[i*ID_W +: ID_W] = (i < 2) ? mask_ff[0]
                                                    : mask_ff[1];
                usable[i] = (i < 6);
            end else begin
                case (msel_ff[2*i +: 2])
                    2'h0: mask_flat[i*ID_W +: ID_W] = mask_ff[0];
                    2'h1: mask_flat[i*ID_W +: ID_W] = mask_ff[1];
                    accept_filter_pkg::MSEL_F15:
                        mask_flat[i*ID_W +: ID_W] = filt_ff[NUM_FILT-1];
                    default: mask_flat[i*ID_W +: ID_W] = '0;
                endcase
                // Sixteen filters, each gated by its enable; filter fifteen is also off while f15_mask makes it a mask.
                usable[i] = fen_ff[i];
                if (i == NUM_FILT - 1 && f15_mask) begin
                    usable[i] = 1'b0;
                end
            end
        end
    end
    filter_match #(.ID_W(ID_W), .NUM_FILT(NUM_FILT)) u_match (
        .id_in   (msg_id_in),
        .filt_in (filt_flat),
        .mask_in (mask_flat),
        .hit_out (hit)
    );
    ////////////////////////////////////////////////////////////////////////
    // Lowest matching filter wins.
    logic [NUM_FILT-1:0] live;
    logic                any;
    logic [3:0]          win;
    always_comb begin
        live = hit & usable;
        any  = 1'b0;
        win  = 4'h0;
        for (int i = NUM_FILT - 1; i >= 0; i--) begin
            if (live[i]) begin
                any = 1'b1;
                win = 4'(i);
            end
        end
    end
    logic       nxt_load;
    logic [3:0] nxt_buf;
    logic [4:0] nxt_hit;
    logic       load_ff;
    logic [3:0] buf_ff;
    logic [4:0] hitc_ff;
    always_comb begin
        nxt_load = 1'b0;
        nxt_buf  = buf_ff;
        nxt_hit  = hitc_ff;
        if (msg_valid_in && any) begin
            nxt_load = 1'b1;
            if (!legacy) begin
                nxt_buf = bassoc_ff[4*win +: 4];
                nxt_hit = {1'b0, win};
            end else if (win > 4'h1) begin
                nxt_buf = accept_filter_pkg::MODE0_BUF1;
                nxt_hit = {1'b0, win};
            end else if (roll_en && buf0_full_in) begin
                nxt_buf = accept_filter_pkg::MODE0_BUF1;
                nxt_hit = {1'b0, win};
            end else if (!buf0_full_in) begin
                nxt_buf = accept_filter_pkg::MODE0_BUF0;
                nxt_hit = win[0] ? accept_filter_pkg::HIT_B0_F1
                                 : accept_filter_pkg::HIT_B0_F0;
            end else begin
                nxt_load = 1'b0; // Buffer zero full without rollover.
            end
        end
    end
    logic [4:0] mem_rd;
    hit_code_mem #(.DEPTH(accept_filter_pkg::NUM_BUF), .AW(4)) u_mem (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .wr_en_in    (nxt_load),
        .wr_addr_in  (nxt_buf),
        .wr_data_in  (nxt_hit),
        .rd_addr_in  (reg_addr_in[3:0]),
        .rd_data_out (mem_rd)
    );
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] nxt_rdata;
    logic        rd_mem_ff, nxt_rd_mem;
    logic [31:0] rdata_ff;
    always_comb begin
        nxt_status = status_ff;
        if (nxt_load) begin
            nxt_status = {23'h0, nxt_hit, nxt_buf};
        end
        nxt_rd_mem = reg_rd_in &&
            (reg_addr_in[7:4] == accept_filter_pkg::OFF_HIT0[7:4]);
        nxt_rdata = 32'h0000_0000;
        if (reg_rd_in) begin
            case (reg_addr_in)
                accept_filter_pkg::OFF_CTRL:   nxt_rdata = ctrl_ff;
                accept_filter_pkg::OFF_FEN:    nxt_rdata = {16'h0, fen_ff};
                accept_filter_pkg::OFF_BASSOC: nxt_rdata = bassoc_ff[31:0];
                accept_filter_pkg::OFF_BASSOC + 8'h01:
                    nxt_rdata = bassoc_ff[63:32];
                accept_filter_pkg::OFF_MSEL:   nxt_rdata = msel_ff;
                accept_filter_pkg::OFF_STATUS: nxt_rdata = status_ff;
                accept_filter_pkg::OFF_MASK0:  nxt_rdata = 32'(mask_ff[0]);
                accept_filter_pkg::OFF_MASK1:  nxt_rdata = 32'(mask_ff[1]);
                default: begin
                    for (int i = 0; i < NUM_FILT; i++) begin
                        if (reg_addr_in ==
                            accept_filter_pkg::OFF_FILT0 + 8'(i)) begin
                            nxt_rdata = 32'(filt_ff[i]);
                        end
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_ff   <= accept_filter_pkg::CTRL_RESET;
            fen_ff    <= 16'h0000;
            bassoc_ff <= 64'h0;
            msel_ff   <= 32'h0;
            status_ff <= 32'h0;
            mask_ff   <= '{default: '0};
            filt_ff   <= '{default: '0};
            load_ff   <= 1'b0;
            buf_ff    <= 4'h0;
            hitc_ff   <= 5'h00;
            rd_mem_ff <= 1'b0;
            rdata_ff  <= 32'h0;
        end else begin
            ctrl_ff   <= nxt_ctrl;
            fen_ff    <= nxt_fen;
            bassoc_ff <= nxt_bassoc;
            msel_ff   <= nxt_msel;
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            filt_ff   <= nxt_filt;
            load_ff   <= nxt_load;
            buf_ff    <= nxt_buf;
            hitc_ff   <= nxt_hit;
            rd_mem_ff <= nxt_rd_mem;
            rdata_ff  <= nxt_rdata;
        end
    end
    assign reg_rdata_out = rd_mem_ff ? {27'h0, mem_rd} : rdata_ff;
    assign load_out      = load_ff;
    assign load_buf_out  = buf_ff;
    assign load_hit_out  = hitc_ff;
    ////////////////////////////////////////////////////////////////////////
    chk_locked_filter: assert property (
        @(posedge clk_in) disable iff (rst_in)
        !$past(cfg) |-> $stable(filt_ff[0]))
        else $error("filter changed outside configuration mode");
    chk_no_match_load: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (msg_valid_in && !any) |=> !load_out)
        else $error("load without a match");
    chk_valid_load: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (!legacy && msg_valid_in && any) |=> load_out)
        else $error("matched message not loaded");
    chk_prio_lowest: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (!legacy && msg_valid_in && live[0]) |=> load_hit_out == 5'h00)
        else $error("lowest filter lost priority");
    chk_buf0_code: assert property (
        @(posedge clk_in) disable iff (rst_in)
        load_out && load_buf_out == 4'h0 && $past(legacy)
        |-> load_hit_out[4:1] == 4'h3)
        else $error("bad buffer zero code");
    chk_buf1_code: assert property (
        @(posedge clk_in) disable iff (rst_in)
        load_out && $past(legacy) && load_hit_out < 5'h02
        |-> $past(roll_en) && load_buf_out == 4'h1)
        else $error("filter 0 or 1 code in buffer one without rollover");
    chk_mode0_range: assert property (
        @(posedge clk_in) disable iff (rst_in)
        load_out && $past(legacy)
        |-> (load_buf_out == 4'h1 && load_hit_out < 5'h06) ||
            (load_buf_out == 4'h0 && load_hit_out[4:1] == 4'h3))
        else $error("mode 0 load outside filters zero to five");
    chk_assoc_buf: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (!legacy && msg_valid_in && any) |=>
        load_buf_out == $past(bassoc_ff[4*win +: 4]))
        else $error("wrong associated buffer");
    chk_enable_gate: assert property (
        @(posedge clk_in) disable iff (rst_in)
        (!legacy && !fen_ff[0]) |-> !live[0])
        else $error("disabled filter compared");
endmodule : can_acceptance_filter
`default_nettype wire

// file: tb/mab_model.sv
// Purpose: Behavioural message assembly side that feeds the filter.
// Assumes: One message per cycle at most; identifier held with valid.
// Notes: The identifier lines scramble only during quiet, while no message is offered.
`timescale 1ns/1ps
`default_nettype none
module mab_model (
    input  wire logic        clk_in,
    output logic             msg_valid_out,
    output logic      [28:0] msg_id_out,
    output logic             buf0_full_out
);
    initial begin
        msg_valid_out = 1'b0;
        msg_id_out    = 29'h0;
        buf0_full_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Offer one assembled message; valid stays high after the cycle until quiet drops it.
    task automatic send(input logic [28:0] id);
        msg_valid_out <= 1'b1;
        msg_id_out    <= id;
        @(posedge clk_in);
    endtask : send

    // Stale identifiers are inverted so nothing can lean on old values.
    task automatic quiet(input int n);
        repeat (n) begin
            msg_valid_out <= 1'b0;
            msg_id_out    <= ~msg_id_out;
            @(posedge clk_in);
        end
    endtask : quiet

    task automatic set_full(input logic f);
        buf0_full_out <= f;
    endtask : set_full
endmodule : mab_model
`default_nettype wire

// file: tb/can_acceptance_filter_test.sv
// Purpose: Self-checking bench for the acceptance filter.
// Assumes: Loads answer one cycle after the message; reads likewise.
// Notes: Expected loads and reads are queued and checked by monitors.
`timescale 1ns/1ps
`default_nettype none
module can_acceptance_filter_test;
    logic        clk_in, rst_in, reg_wr, reg_rd, rd_pend, load;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic        msg_valid, buf0_full, cfg = 1'b1, roll = 1'b0, f15m = 1'b0;
    logic        full = 1'b0;
    logic [28:0] msg_id, id, filt [16], mask [2], pool [6];
    logic [1:0]  mode = 2'h0, msel [16];
    logic [3:0]  load_buf, bas [16];
    logic [4:0]  load_hit, hit_sh [16];
    logic [15:0] fen;
    logic [31:0] v, st;
    bit          known [16];
    logic [8:0]  lq [$];
    logic [31:0] rq [$];
    int          n_mismatch = 0, n_compared = 0, md, n, r;

    can_acceptance_filter can_acceptance_filter_i (
        .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .msg_valid_in(msg_valid),
        .msg_id_in(msg_id), .buf0_full_in(buf0_full), .load_out(load),
        .load_buf_out(load_buf), .load_hit_out(load_hit));
    mab_model mab_model_i (.clk_in(clk_in), .msg_valid_out(msg_valid),
        .msg_id_out(msg_id), .buf0_full_out(buf0_full));

    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_compared > 0 && n_mismatch == 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    always @(posedge clk_in) begin
        if (rd_pend) check("read data", rq.pop_front(), reg_rdata);
        rd_pend <= reg_rd;
        if (load === 1'b1)
            check("load", lq.size() ? 32'(lq.pop_front()) : 32'hffff_ffff,
                  {23'h0, load_buf, load_hit});
    end

    ////////////////////////////////////////////////////////////////////
    // The shadow only takes filters and masks while configuring.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        reg_wr <= 1'b1; reg_rd <= 1'b0; reg_addr <= a; reg_wdata <= d;
        if (a == accept_filter_pkg::OFF_CTRL) begin
            cfg = d[0]; mode = d[2:1]; roll = d[3]; f15m = d[4];
        end else if (a == accept_filter_pkg::OFF_FEN) fen = d[15:0];
        else if (a == 8'h02 || a == 8'h03)
            for (i = 0; i < 8; i++) bas[a[0]*8+i] = d[4*i+:4];
        else if (a == accept_filter_pkg::OFF_MSEL)
            for (i = 0; i < 16; i++) msel[i] = d[2*i+:2];
        else if (cfg && a[7:1] == 7'h04) mask[a[0]] = d[28:0];
        else if (cfg && a[7:4] == 4'h1) filt[a[3:0]] = d[28:0];
        @(posedge clk_in);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_rd <= 1'b1; reg_wr <= 1'b0; reg_addr <= a;
        rq.push_back(e);
        @(posedge clk_in);
    endtask : rd

    task automatic idle;
        reg_wr <= 1'b0; reg_rd <= 1'b0;
        @(posedge clk_in);
    endtask : idle

    // The shadow flag is set at once, because the model's pin moves by a nonblocking
    // assignment in this same time step, before the next message is sampled.
    task automatic set_full(input logic f);
        full = f;
        mab_model_i.set_full(f);
    endtask : set_full

    function automatic logic [9:0] expect_of(logic [28:0] i, logic full);
        logic [28:0] m;
        for (int k = 0; k < 16; k++) begin
            if (mode == accept_filter_pkg::MODE_LEGACY) begin
                if (k > 5) return 10'h0;
                m = (k < 2) ? mask[0] : mask[1];
            end else begin
                if (!fen[k] || (f15m && k == 15)) continue;
                m = msel[k] == 0 ? mask[0] : msel[k] == 1 ? mask[1] :
                    msel[k] == 2 ? filt[15] : 29'h0;
            end
            if (((i ^ filt[k]) & m) != 0) continue;
            if (mode != accept_filter_pkg::MODE_LEGACY)
                return {1'b1, bas[k], 5'(k)};
            if (k > 1 || (full && roll))
                return {1'b1, accept_filter_pkg::MODE0_BUF1, 5'(k)};
            if (full) return 10'h0;
            return {1'b1, accept_filter_pkg::MODE0_BUF0,
                    k ? accept_filter_pkg::HIT_B0_F1
                      : accept_filter_pkg::HIT_B0_F0};
        end
        return 10'h0;
    endfunction : expect_of

    task automatic msg(input logic [28:0] i);
        logic [9:0] e;
        e = expect_of(i, full);
        if (e[9]) begin
            lq.push_back(e[8:0]);
            st = {23'h0, e[4:0], e[8:5]};
            hit_sh[e[8:5]] = e[4:0];
            known[e[8:5]] = 1'b1;
        end
        mab_model_i.send(i);
    endtask : msg

    task automatic hits;
        mab_model_i.quiet(2);
        for (int b = 0; b < 16; b++)
            if (known[b]) rd(8'(accept_filter_pkg::OFF_HIT0 + b),
                             {27'h0, hit_sh[b]});
        rd(accept_filter_pkg::OFF_STATUS, st);
        idle();
    endtask : hits

    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        rst_in = 1'b1; reg_wr = 0; reg_rd = 0; rd_pend = 0;
        reg_addr = 8'h0; reg_wdata = 32'h0;
        void'($urandom(32'hd3cc));
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(accept_filter_pkg::OFF_CTRL, accept_filter_pkg::CTRL_RESET);
        rd(8'hff, 32'h0);
        wr(accept_filter_pkg::OFF_MASK0, 32'h1fff_ffff);
        wr(accept_filter_pkg::OFF_MASK1, 32'h1fff_fff0);
        for (n = 0; n < 6; n++) wr(8'(8'h10 + n), $urandom & 32'h1fff_fff0);
        wr(accept_filter_pkg::OFF_CTRL, 32'h0);
        idle();
        msg(filt[0]);
        msg(filt[1]);
        for (n = 2; n < 6; n++) msg(filt[n] | 29'h5);
        msg(filt[2] ^ 29'h100);
        set_full(1'b1);
        msg(filt[0]);
        mab_model_i.quiet(1);
        wr(accept_filter_pkg::OFF_CTRL, 32'h8);
        wr(accept_filter_pkg::OFF_FILT0, {3'h0, ~filt[0]});
        idle();
        msg(filt[0]);
        msg(filt[1]);
        set_full(1'b0);
        msg(filt[0]);
        hits();
        for (md = 1; md < 3; md++) begin
            wr(accept_filter_pkg::OFF_CTRL, 32'(md * 2 + 1));
            wr(accept_filter_pkg::OFF_MASK1, $urandom);
            for (n = 0; n < 6; n++) pool[n] = 29'($urandom);
            for (n = 0; n < 16; n++)
                wr(8'(8'h10 + n), {3'h0, pool[$urandom % 6]});
            wr(accept_filter_pkg::OFF_FEN, $urandom);
            wr(8'h02, $urandom);
            wr(8'h03, $urandom);
            for (n = 0; n < 16; n++) begin
                r = $urandom % 4;
                v[2*n+:2] = (r == 2) ? 2'h0 : 2'(r);
            end
            wr(accept_filter_pkg::OFF_MSEL, v);
            wr(accept_filter_pkg::OFF_CTRL, 32'(md * 2));
            idle();
            repeat (40) begin
                id = pool[$urandom % 6];
                if ($urandom % 3 == 0) id[$urandom % 29] ^= 1'b1;
                msg(id);
                mab_model_i.quiet($urandom % 2);
            end
            hits();
            wr(accept_filter_pkg::OFF_CTRL, 32'(md * 2 + 17));
            wr(8'h1f, 32'h1fff_ff00);
            wr(accept_filter_pkg::OFF_FEN, 32'h8001);
            wr(accept_filter_pkg::OFF_MSEL, 32'h2);
            wr(accept_filter_pkg::OFF_CTRL, 32'(md * 2 + 16));
            idle();
            msg(filt[0] ^ 29'h3);
            msg(filt[0] ^ 29'h100);
            msg(filt[15]);
            hits();
        end
        mab_model_i.quiet(4);
        check("pending loads", 32'h0, 32'(lq.size()));
        end_of_test();
    end
endmodule : can_acceptance_filter_test
`default_nettype wire
